//--- hw/isc_pkg.sv
package isc_pkg;

  // Register byte offsets
  localparam logic [7:0] ISC_OFS_MODE_SEL = 8'h00;
  localparam logic [7:0] ISC_OFS_CONTROL  = 8'h04;
  localparam logic [7:0] ISC_OFS_STATUS   = 8'h08;

  // standby_mode_select_reg fields
  localparam int ISC_SEL_LO_BIT = 0;
  localparam int ISC_SEL_HI_BIT = 1;
  localparam logic [1:0] ISC_MODE_DEEP_IDLE = 2'h0;
  localparam logic [1:0] ISC_MODE_SEL_RST   = 2'h0;

  // standby_control_reg fields
  localparam int ISC_STOP_BIT      = 1;
  localparam int ISC_NMI0_DIS_BIT  = 2;
  localparam int ISC_NMI1_DIS_BIT  = 3;
  localparam int ISC_MASK_DIS_BIT  = 4;
  localparam logic [3:0] ISC_CTL_RST = 4'h0;

  // Status register fields
  localparam int ISC_ST_STATE_LSB = 0;
  localparam int ISC_ST_CAUSE_LSB = 4;

  // Wake cause codes
  localparam logic [2:0] ISC_CAUSE_NONE   = 3'h0;
  localparam logic [2:0] ISC_CAUSE_NMI    = 3'h1;
  localparam logic [2:0] ISC_CAUSE_EXT    = 3'h2;
  localparam logic [2:0] ISC_CAUSE_PERIPH = 3'h3;
  localparam logic [2:0] ISC_CAUSE_RESET  = 3'h4;

  // Priority: smaller code is more urgent
  localparam int ISC_PRIO_W = 3;
  localparam int ISC_EXT_N  = 8;

  // AHB
  localparam logic [1:0] ISC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ISC_HSIZE_WORD    = 3'h2;
  localparam logic [31:0] ISC_RDATA_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    ISC_ST_RUN   = 2'b00,
    ISC_ST_ENTER = 2'b01,
    ISC_ST_IDLE  = 2'b10,
    ISC_ST_WAKE  = 2'b11
  } isc_state_t;

  typedef struct packed {
    logic pin;
    logic wdt2;
    logic lvd;
    logic clkmon;
  } isc_rst_src_t;

  typedef struct packed {
    logic nmi0_dis;
    logic nmi1_dis;
    logic mask_dis;
  } isc_disable_t;

  typedef struct packed {
    logic                  wake;
    logic                  ack;
    logic                  hold;
    logic [2:0]            cause;
  } isc_wake_t;

endpackage

//--- hw/isc_clk_gate.sv
`timescale 1ns/1ps
`default_nettype none
module isc_clk_gate
  import isc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic run_req,
  output var  logic clk_en_r
);

  // Enable moves only at a clock edge, so a downstream gate sees whole pulses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clk_en_r <= 1'b1;
    end else begin
      clk_en_r <= run_req;
    end
  end

endmodule // isc_clk_gate
`default_nettype wire

//--- hw/isc_wake_detect.sv
`timescale 1ns/1ps
`default_nettype none
module isc_wake_detect
  import isc_pkg::*;
#(
  parameter int PERIPH_N = 4
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  nmi_pin_req,
  input  wire logic                  watchdog_two_nonmask_req,
  input  wire logic [ISC_EXT_N-1:0]  external_irq_pins,
  input  wire logic [ISC_EXT_N-1:0]  external_irq_unmask,
  input  wire logic [PERIPH_N-1:0]   periph_irq_req,
  input  wire logic [PERIPH_N-1:0]   periph_irq_unmask,
  input  wire logic [ISC_PRIO_W-1:0] maskable_req_prio,
  input  wire logic                  isr_active,
  input  wire logic [ISC_PRIO_W-1:0] isr_prio,
  input  wire isc_disable_t          dis,
  output var isc_wake_t              wake_r
);

  logic nmi_hit;
  logic ext_hit;
  logic per_hit;
  logic prio_ok;

  assign nmi_hit = (nmi_pin_req & ~dis.nmi0_dis) |
                   (watchdog_two_nonmask_req & ~dis.nmi1_dis);
  assign ext_hit = |(external_irq_pins & external_irq_unmask) & ~dis.mask_dis;
  assign per_hit = |(periph_irq_req & periph_irq_unmask) & ~dis.mask_dis;
  assign prio_ok = ~isr_active | (maskable_req_prio < isr_prio);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_r <= '0;
    end else begin
      wake_r.wake <= nmi_hit | ext_hit | per_hit;
      wake_r.ack  <= nmi_hit | prio_ok;
      wake_r.hold <= ~nmi_hit & ~prio_ok;
      if (nmi_hit) begin
        wake_r.cause <= ISC_CAUSE_NMI;
      end else if (ext_hit) begin
        wake_r.cause <= ISC_CAUSE_EXT;
      end else if (per_hit) begin
        wake_r.cause <= ISC_CAUSE_PERIPH;
      end else begin
        wake_r.cause <= ISC_CAUSE_NONE;
      end
    end
  end

endmodule // isc_wake_detect
`default_nettype wire

//--- hw/isc_idle_standby_control.sv
// Behaviour
// - Writing 1 to the stop bit while the mode field is 00 in normal run enters deep idle.
// - Oscillator, PLL and flash run enables stay asserted through deep idle.
// - CPU and main-clock peripheral clock enables drop while in deep idle.
// - RAM retention stays asserted across entry, idle and wake.
// - Subclock and external-clock peripherals keep their clock during deep idle.
// - Wake restores the CPU clock with no stabilisation wait.
// - A request already pending at entry ends deep idle at once.
// - Unmasked NMI, watchdog NMI, external pin or running peripheral requests end deep idle.
// - Any reset source ends deep idle.
// - Every release from deep idle returns to normal run.
// - Any enabled NMI or unmasked maskable request wakes regardless of priority.
// - Inside a service routine a lower priority request wakes but is not acknowledged.
// - Such an unacknowledged waking request stays pending in the interrupt controller.
// - Inside a service routine a higher priority or NMI request wakes and is acknowledged.
// - Requests disabled by the two NMI disable bits or the maskable disable bit never wake.
`timescale 1ns/1ps
`default_nettype none
module isc_idle_standby_control
  import isc_pkg::*;
#(
  parameter int PERIPH_N = 4
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  // Wake sources
  input  wire logic                  nmi_pin_req,
  input  wire logic                  watchdog_two_nonmask_req,
  input  wire logic [ISC_EXT_N-1:0]  external_irq_pins,
  input  wire logic [ISC_EXT_N-1:0]  external_irq_unmask,
  input  wire logic [PERIPH_N-1:0]   periph_irq_req,
  input  wire logic [PERIPH_N-1:0]   periph_irq_unmask,
  input  wire logic [ISC_PRIO_W-1:0] maskable_req_prio,
  input  wire logic                  isr_active,
  input  wire logic [ISC_PRIO_W-1:0] isr_prio,
  input  wire isc_rst_src_t          rst_src,
  // Clock and power controls
  output var  logic                  cpu_clk_en,
  output var  logic                  periph_clk_en,
  output var  logic                  subclk_periph_en,
  output var  logic                  osc_run,
  output var  logic                  pll_run,
  output var  logic                  flash_run,
  output var  logic                  ram_retain,
  output var  logic                  deep_idle_mode,
  output var  logic                  irq_ack_grant,
  output var  logic                  irq_hold_pending
);

  isc_state_t   state_r;
  isc_state_t   state_nxt;
  logic [1:0]   mode_sel_r;
  logic         stop_r;
  isc_disable_t dis_r;
  logic [2:0]   cause_r;
  isc_wake_t    wake;
  logic         any_rst;
  logic         run_req;

  // Bus phase tracking
  logic         dph_r;
  logic         dph_wr_r;
  logic [7:0]   dph_addr_r;
  logic         addr_ok;
  logic         wr_stb;
  logic [31:0]  rd_mux;
  logic         take;
  logic         ctl_wr;
  logic         rel_edge;

  assign any_rst = rst_src.pin | rst_src.wdt2 | rst_src.lvd | rst_src.clkmon;
  assign addr_ok = hsel & hready & (htrans == ISC_HTRANS_NONSEQ);
  assign wr_stb  = dph_r & dph_wr_r;
  assign take    = addr_ok & ~dph_r;
  assign ctl_wr  = wr_stb & (dph_addr_r == ISC_OFS_CONTROL);

  isc_wake_detect #(
    .PERIPH_N (PERIPH_N)
  ) u_wake (
    .core_clk                 (core_clk),
    .sys_rst                  (sys_rst),
    .nmi_pin_req              (nmi_pin_req),
    .watchdog_two_nonmask_req (watchdog_two_nonmask_req),
    .external_irq_pins        (external_irq_pins),
    .external_irq_unmask      (external_irq_unmask),
    .periph_irq_req           (periph_irq_req),
    .periph_irq_unmask        (periph_irq_unmask),
    .maskable_req_prio        (maskable_req_prio),
    .isr_active               (isr_active),
    .isr_prio                 (isr_prio),
    .dis                      (dis_r),
    .wake_r                   (wake)
  );

  // AHB address/data phase: one wait state on every transfer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dph_r      <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_r <= take;
      if (take) begin
        dph_wr_r   <= hwrite;
        dph_addr_r <= haddr;
      end
    end
  end

  // Ready low for the cycle after each accepted address phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= ~take;
    end
  end

  // Every transfer answers OKAY, unmapped ones included
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Read data picked by the address held from the address phase
  always_comb begin
    rd_mux = ISC_RDATA_ZERO;
    case (dph_addr_r)
      ISC_OFS_MODE_SEL: begin
        rd_mux[ISC_SEL_HI_BIT:ISC_SEL_LO_BIT] = mode_sel_r;
      end
      ISC_OFS_CONTROL: begin
        rd_mux[ISC_STOP_BIT]     = stop_r;
        rd_mux[ISC_NMI0_DIS_BIT] = dis_r.nmi0_dis;
        rd_mux[ISC_NMI1_DIS_BIT] = dis_r.nmi1_dis;
        rd_mux[ISC_MASK_DIS_BIT] = dis_r.mask_dis;
      end
      ISC_OFS_STATUS: begin
        rd_mux[ISC_ST_STATE_LSB+1:ISC_ST_STATE_LSB] = state_r;
        rd_mux[ISC_ST_CAUSE_LSB+2:ISC_ST_CAUSE_LSB] = cause_r;
      end
      default: begin
        rd_mux = ISC_RDATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata <= ISC_RDATA_ZERO;
    end else if (dph_r && !dph_wr_r) begin
      hrdata <= rd_mux;
    end
  end

  // Mode select register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_sel_r <= ISC_MODE_SEL_RST;
    end else if (wr_stb && dph_addr_r == ISC_OFS_MODE_SEL) begin
      mode_sel_r <= hwdata[ISC_SEL_HI_BIT:ISC_SEL_LO_BIT];
    end
  end

  // Control register: disable bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dis_r <= '0;
    end else if (ctl_wr) begin
      dis_r.nmi0_dis <= hwdata[ISC_NMI0_DIS_BIT];
      dis_r.nmi1_dis <= hwdata[ISC_NMI1_DIS_BIT];
      dis_r.mask_dis <= hwdata[ISC_MASK_DIS_BIT];
    end
  end

  // Stop bit: set by software, cleared by hardware on release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stop_r <= 1'b0;
    end else if (any_rst || state_r == ISC_ST_WAKE) begin
      stop_r <= 1'b0;
    end else if (ctl_wr && state_r == ISC_ST_RUN) begin
      stop_r <= hwdata[ISC_STOP_BIT] && mode_sel_r == ISC_MODE_DEEP_IDLE;
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ISC_ST_RUN: begin
        if (stop_r && !any_rst) begin
          state_nxt = ISC_ST_ENTER;
        end
      end
      ISC_ST_ENTER: begin
        if (any_rst || wake.wake) begin
          state_nxt = ISC_ST_WAKE;
        end else begin
          state_nxt = ISC_ST_IDLE;
        end
      end
      ISC_ST_IDLE: begin
        if (any_rst || wake.wake) begin
          state_nxt = ISC_ST_WAKE;
        end
      end
      ISC_ST_WAKE: begin
        state_nxt = ISC_ST_RUN;
      end
      default: begin
        state_nxt = ISC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ISC_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One-cycle strobe on the edge that enters the wake state
  assign rel_edge = (state_nxt == ISC_ST_WAKE) && (state_r != ISC_ST_WAKE);

  // Wake cause capture
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cause_r <= ISC_CAUSE_NONE;
    end else if (rel_edge) begin
      cause_r <= any_rst ? ISC_CAUSE_RESET : wake.cause;
    end
  end

  // Acknowledge decision presented to the interrupt controller at release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_ack_grant    <= 1'b0;
      irq_hold_pending <= 1'b0;
    end else if (rel_edge && !any_rst) begin
      irq_ack_grant    <= wake.ack;
      irq_hold_pending <= wake.hold;
    end else begin
      irq_ack_grant    <= 1'b0;
      irq_hold_pending <= 1'b0;
    end
  end

  // Gate off while entering or idle; back on the wake edge, no wait
  assign run_req = (state_nxt == ISC_ST_RUN) || (state_nxt == ISC_ST_WAKE);

  isc_clk_gate u_cpu_gate (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run_req  (run_req),
    .clk_en_r (cpu_clk_en)
  );

  isc_clk_gate u_periph_gate (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run_req  (run_req),
    .clk_en_r (periph_clk_en)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      deep_idle_mode <= 1'b0;
    end else begin
      deep_idle_mode <= (state_nxt == ISC_ST_ENTER) || (state_nxt == ISC_ST_IDLE);
    end
  end

  // Always-on supplies and clocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc_run          <= 1'b1;
      pll_run          <= 1'b1;
      flash_run        <= 1'b1;
      ram_retain       <= 1'b1;
      subclk_periph_en <= 1'b1;
    end else begin
      osc_run          <= 1'b1;
      pll_run          <= 1'b1;
      flash_run        <= 1'b1;
      ram_retain       <= 1'b1;
      subclk_periph_en <= 1'b1;
    end
  end

endmodule // isc_idle_standby_control
`default_nettype wire

//--- tb/isc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module isc_assertions
  import isc_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         sys_rst,
  input wire logic         cpu_clk_en,
  input wire logic         periph_clk_en,
  input wire logic         subclk_periph_en,
  input wire logic         osc_run,
  input wire logic         pll_run,
  input wire logic         flash_run,
  input wire logic         ram_retain,
  input wire logic         deep_idle_mode,
  input wire logic         irq_ack_grant,
  input wire logic         irq_hold_pending,
  input wire isc_rst_src_t rst_src
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_run; osc_run && pll_run && flash_run; endproperty
  a_run: assert property (p_run) else $error("main clock source stopped");
  property p_ram; ram_retain; endproperty
  a_ram: assert property (p_ram) else $error("ram retention dropped");
  property p_sub; subclk_periph_en; endproperty
  a_sub: assert property (p_sub) else $error("subclock peripherals stopped");
  property p_gate; deep_idle_mode |-> !cpu_clk_en && !periph_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("clock runs in idle");
  property p_drop; $fell(cpu_clk_en) |-> deep_idle_mode; endproperty
  a_drop: assert property (p_drop) else $error("clock dropped outside idle");
  property p_ret; $fell(deep_idle_mode) |-> cpu_clk_en && periph_clk_en; endproperty
  a_ret: assert property (p_ret) else $error("clock late after idle");
  property p_rst; deep_idle_mode && rst_src != 4'h0 |=> !deep_idle_mode; endproperty
  a_rst: assert property (p_rst) else $error("reset source did not end idle");
  property p_pls;
    irq_ack_grant || irq_hold_pending |-> $fell(deep_idle_mode)
      && !(irq_ack_grant && irq_hold_pending) ##1 !irq_ack_grant && !irq_hold_pending;
  endproperty
  a_pls: assert property (p_pls) else $error("bad ack or hold pulse");
endmodule // isc_assertions

bind isc_idle_standby_control isc_assertions u_chk (
  .core_clk, .sys_rst, .cpu_clk_en, .periph_clk_en, .subclk_periph_en, .osc_run,
  .pll_run, .flash_run, .ram_retain, .deep_idle_mode, .irq_ack_grant,
  .irq_hold_pending, .rst_src
);
`default_nettype wire

//--- tb/isc_irq_partner.sv
`timescale 1ns/1ps
`default_nettype none
module isc_irq_partner (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [13:0] set_req,
  input  wire logic        clr_req,
  input  wire logic        irq_ack_grant,
  output logic             nmi_pin_req,
  output logic             watchdog_two_nonmask_req,
  output logic [7:0]       external_irq_pins,
  output logic [3:0]       periph_irq_req
);
  logic [13:0] req_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || clr_req || irq_ack_grant) begin
      req_r <= 14'h0000;
    end else begin
      req_r <= req_r | set_req;
    end
  end
  assign {periph_irq_req, external_irq_pins, watchdog_two_nonmask_req, nmi_pin_req} = req_r;
endmodule // isc_irq_partner
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import isc_pkg::*;
;
  logic         core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, clr_req;
  logic         cpu_clk_en, periph_clk_en, deep_idle_mode, irq_ack_grant;
  logic         irq_hold_pending, isr_active, nmi_pin_req, watchdog_two_nonmask_req;
  logic [1:0]   htrans;
  logic [2:0]   maskable_req_prio, isr_prio;
  logic [3:0]   periph_irq_req, periph_irq_unmask;
  logic [7:0]   haddr, external_irq_pins, external_irq_unmask;
  logic [13:0]  set_req;
  logic [31:0]  hwdata, hrdata, rd;
  isc_rst_src_t rst_src;
  int           err_total, check_count;

  isc_idle_standby_control dut (
    .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(ISC_HSIZE_WORD),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .nmi_pin_req,
    .watchdog_two_nonmask_req, .external_irq_pins, .external_irq_unmask,
    .periph_irq_req, .periph_irq_unmask, .maskable_req_prio, .isr_active, .isr_prio,
    .rst_src, .cpu_clk_en, .periph_clk_en, .subclk_periph_en(), .osc_run(),
    .pll_run(), .flash_run(), .ram_retain(), .deep_idle_mode, .irq_ack_grant,
    .irq_hold_pending
  );
  isc_irq_partner u_irq (
    .core_clk, .sys_rst, .set_req, .clr_req, .irq_ack_grant, .nmi_pin_req,
    .watchdog_two_nonmask_req, .external_irq_pins, .periph_irq_req
  );

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tmo;
    err_total++;
    test_done();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'h1;
    htrans <= ISC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    rd = hrdata;
    chk("hresp", ISC_RDATA_ZERO, {31'h0000_0000, hresp});
    if (n >= 50) tmo();
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, ISC_RDATA_ZERO);
    chk(nm, e, rd);
  endtask

  task automatic raise(input logic [13:0] m);
    set_req <= m;
    @(posedge core_clk);
    set_req <= 14'h0000;
  endtask

  task automatic clr;
    clr_req <= 1'h1;
    @(posedge core_clk);
    clr_req <= 1'h0;
  endtask

  task automatic go_idle(input logic [31:0] ctl);
    bus(1'h1, ISC_OFS_CONTROL, ctl | 32'h0000_0002);
    repeat (5) @(posedge core_clk);
    chk("idle", 1'h1, deep_idle_mode);
    chk("cpu_clk", 1'h0, cpu_clk_en);
    chk("per_clk", 1'h0, periph_clk_en);
  endtask

  task automatic wake_chk(input logic a, input logic h, input logic [2:0] c);
    int n;
    n = 0;
    while (deep_idle_mode !== 1'h0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) tmo();
    chk("ack", a, irq_ack_grant);
    chk("hold", h, irq_hold_pending);
    chk("cpu_clk", 1'h1, cpu_clk_en);
    rdchk("status", ISC_OFS_STATUS, {25'h000_0000, c, 4'h0});
  endtask

  task automatic s_regs;
    rdchk("mode", ISC_OFS_MODE_SEL, ISC_RDATA_ZERO);
    rdchk("ctl", ISC_OFS_CONTROL, ISC_RDATA_ZERO);
    rdchk("status", ISC_OFS_STATUS, ISC_RDATA_ZERO);
    rdchk("unmapped", 8'h0C, ISC_RDATA_ZERO);
    bus(1'h1, ISC_OFS_MODE_SEL, 32'h0000_0003);
    rdchk("mode", ISC_OFS_MODE_SEL, 32'h0000_0003);
    bus(1'h1, ISC_OFS_CONTROL, 32'h0000_0002);
    repeat (5) @(posedge core_clk);
    chk("no_idle", 1'h0, deep_idle_mode);
    bus(1'h1, ISC_OFS_MODE_SEL, ISC_RDATA_ZERO);
  endtask

  task automatic s_wake;
    for (int i = 0; i < 14; i++) begin
      go_idle(ISC_RDATA_ZERO);
      raise(14'h0001 << i);
      wake_chk(1'h1, 1'h0,
               i < 2 ? ISC_CAUSE_NMI : (i < 10 ? ISC_CAUSE_EXT : ISC_CAUSE_PERIPH));
    end
  endtask

  task automatic s_block;
    external_irq_unmask <= 8'hFD;
    for (int i = 0; i < 4; i++) begin
      go_idle(i < 3 ? (32'h0000_0004 << i) : ISC_RDATA_ZERO);
      raise(14'h0001 << i);
      repeat (10) @(posedge core_clk);
      chk("blocked", 1'h1, deep_idle_mode);
      rdchk("st_idle", ISC_OFS_STATUS,
            {25'h000_0000, (i == 0 ? ISC_CAUSE_PERIPH : ISC_CAUSE_RESET), 4'h2});
      rdchk("ctl_idle", ISC_OFS_CONTROL,
            (i < 3 ? (32'h0000_0004 << i) : ISC_RDATA_ZERO) | 32'h0000_0002);
      rst_src <= isc_rst_src_t'(4'h1 << i);
      wake_chk(1'h0, 1'h0, ISC_CAUSE_RESET);
      rst_src <= 4'h0;
      clr();
    end
    external_irq_unmask <= 8'hFF;
  endtask

  task automatic s_prio;
    logic h;
    isr_active <= 1'h1;
    isr_prio <= 3'h3;
    for (int i = 0; i < 3; i++) begin
      h = i < 2;
      maskable_req_prio <= 3'h5 - 3'(2 * i);
      go_idle(ISC_RDATA_ZERO);
      raise(14'h0004);
      wake_chk(!h, h, ISC_CAUSE_EXT);
      chk("pending", h, external_irq_pins[0]);
      clr();
    end
    maskable_req_prio <= 3'h7;
    go_idle(ISC_RDATA_ZERO);
    raise(14'h0001);
    wake_chk(1'h1, 1'h0, ISC_CAUSE_NMI);
    isr_active <= 1'h0;
  endtask

  task automatic s_pend;
    raise(14'h0004);
    bus(1'h1, ISC_OFS_CONTROL, 32'h0000_0002);
    repeat (6) @(posedge core_clk);
    chk("imm_exit", 1'h0, deep_idle_mode);
    rdchk("status", ISC_OFS_STATUS, {25'h000_0000, ISC_CAUSE_EXT, 4'h0});
  endtask

  initial begin
    err_total = 0;
    check_count = 0;
    sys_rst = 1'h1;
    {hsel, hwrite, clr_req, isr_active} = 4'h0;
    {htrans, haddr, hwdata, set_req} = 56'h0;
    {maskable_req_prio, isr_prio, rst_src} = 10'h000;
    external_irq_unmask = 8'hFF;
    periph_irq_unmask = 4'hF;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    s_regs();
    s_wake();
    s_block();
    s_prio();
    s_pend();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
